// file: pbch_pkg.sv
/*
  Package for the bridge configuration header register bank (offsets 04h to 18h).
  Holds offsets, field positions, reset values and the event carrier struct.
  Assumes a classic Wishbone slave with 32-bit data and byte addressing.
*/
// Overview of operation
// - Interrupt status bit 19 always reads zero, unaffected by forwarded interrupts.
// - Capability-list bit 20 is read-only one, pointer lives at 34h.
// - Bits 21, 23 and select timing 26:25 are read-only zero.
// - Master data parity error bit 24 sets on requester parity error if enabled; W1C.
// - Signaled target abort bit 27 sets on completer abort sent; read-only.
// - Received target abort bit 28 sets on completer abort completion received.
// - Received master abort bit 29 sets on unsupported request completion received.
// - Signaled system error bit 30 sets on fatal/nonfatal message when enabled; W1C.
// - Detected parity error bit 31 sets on poisoned TLP received; W1C.
// - Fixed read-only revision identifier in low byte at 08h.
// - Class code reads 06h, 04h, 00h; read-only.
// - Cache line size is read/write, resets to zero, drives nothing.
// - Primary latency timer byte at 0Ch bits 15:8 reads zero.
// - Header type byte at 0Ch bits 23:16 reads 01h.
// - Primary bus number at 18h bits 7:0 is read/write, resets zero.
// - Secondary bus number at 18h bits 15:8 is read/write, resets zero.
// - Parity error response enable, command bit 6, gates master data parity error bit 24 only.
// - System error reporting enable, command bit 8, gates error reporting.
`default_nettype none

package pbch_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PBCH_OFS_CMD_STATUS = 8'h04;
  localparam logic [7:0] PBCH_OFS_CLASS_REV  = 8'h08;
  localparam logic [7:0] PBCH_OFS_HDR_CACHE  = 8'h0C;
  localparam logic [7:0] PBCH_OFS_BUS_NUMBER = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int PBCH_BIT_PERR_RESP_EN   = 6;
  localparam int PBCH_BIT_SERR_EN        = 8;
  localparam int PBCH_BIT_INT_STATUS     = 19;
  localparam int PBCH_BIT_CAP_LIST       = 20;
  localparam int PBCH_BIT_MASTER_PERR    = 24;
  localparam int PBCH_BIT_SIG_TGT_ABORT  = 27;
  localparam int PBCH_BIT_RCV_TGT_ABORT  = 28;
  localparam int PBCH_BIT_RCV_MST_ABORT  = 29;
  localparam int PBCH_BIT_SIG_SYS_ERR    = 30;
  localparam int PBCH_BIT_DET_PERR       = 31;

  // ==========================================================================
  // Fixed and reset values
  localparam logic [7:0]  PBCH_CLASS_BASE    = 8'h06;
  localparam logic [7:0]  PBCH_CLASS_SUB     = 8'h04;
  localparam logic [7:0]  PBCH_CLASS_PROG    = 8'h00;
  localparam logic [7:0]  PBCH_LAT_TIMER     = 8'h00;
  localparam logic [7:0]  PBCH_HEADER_TYPE   = 8'h01;
  localparam logic [7:0]  PBCH_BYTE_RESET    = 8'h00;
  localparam logic        PBCH_CAP_LIST_VAL  = 1'b1;
  localparam logic [31:0] PBCH_UNMAPPED_DATA = 32'h0000_0000;

  // Events from the port's completion and error logic, one-cycle pulses
  typedef struct packed {
    logic parity_err;
    logic cpl_abort_sent;
    logic cpl_abort_rcvd;
    logic cpl_ur_rcvd;
    logic err_msg_sent;
    logic poisoned_rcvd;
  } pbch_event_type;

endpackage

`default_nettype wire

// file: pbch_config_header.sv
/*
  Bridge configuration header register bank, offsets 04h to 18h, with the
  parity/system-error enables of the command half-word.
  Assumes a classic Wishbone master on sys_clk and event pulses from logic on
  the same clock, so no synchronisers are needed.
*/
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module pbch_config_header
  import pbch_pkg::*;
#(
  parameter logic [7:0] DEVICE_REVISION = 8'h5A  // Arbitrary value
) (
  input  wire logic           sys_clk,
  input  wire logic           rst_n,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output var  logic [31:0]    wb_dat_o,
  output var  logic           wb_ack_o,
  input  wire pbch_event_type events,
  output var  logic           parity_err_resp_en,
  output var  logic           system_error_report_enable,
  output var  logic [7:0]     upstream_bus_number,
  output var  logic [7:0]     downstream_bus_number
);

  // ==========================================================================
  // Bus decode
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] w1c;
  logic        hit_status;

  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr         = req && wb_we_i;
  assign wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign hit_status = wr && (wb_adr_i == PBCH_OFS_CMD_STATUS);
  assign w1c        = hit_status ? (wb_dat_i & wmask) : 32'h0000_0000;

  // ==========================================================================
  // Command enables
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      parity_err_resp_en         <= 1'b0;
      system_error_report_enable <= 1'b0;
    end else if (hit_status && wb_sel_i[0]) begin
      parity_err_resp_en <= wb_dat_i[PBCH_BIT_PERR_RESP_EN];
    end
    if (rst_n && hit_status && wb_sel_i[1]) begin
      system_error_report_enable <= wb_dat_i[PBCH_BIT_SERR_EN];
    end
  end

  // ==========================================================================
  // Status flags
  logic master_perr;
  logic sig_tgt_abort;
  logic rcv_tgt_abort;
  logic rcv_mst_abort;
  logic sig_sys_err;
  logic det_perr;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      master_perr <= 1'b0;
    end else if (events.parity_err && parity_err_resp_en) begin
      master_perr <= 1'b1;
    end else if (w1c[PBCH_BIT_MASTER_PERR]) begin
      master_perr <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sig_sys_err <= 1'b0;
    end else if (events.err_msg_sent && system_error_report_enable) begin
      sig_sys_err <= 1'b1;
    end else if (w1c[PBCH_BIT_SIG_SYS_ERR]) begin
      sig_sys_err <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      det_perr <= 1'b0;
    end else if (events.poisoned_rcvd) begin
      det_perr <= 1'b1;
    end else if (w1c[PBCH_BIT_DET_PERR]) begin
      det_perr <= 1'b0;
    end
  end

  // Read-only sticky flags: software cannot clear them, only reset does
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sig_tgt_abort <= 1'b0;
      rcv_tgt_abort <= 1'b0;
      rcv_mst_abort <= 1'b0;
    end else begin
      sig_tgt_abort <= sig_tgt_abort | events.cpl_abort_sent;
      rcv_tgt_abort <= rcv_tgt_abort | events.cpl_abort_rcvd;
      rcv_mst_abort <= rcv_mst_abort | events.cpl_ur_rcvd;
    end
  end

  // ==========================================================================
  // Writable bytes
  logic [7:0] cache_line_length;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cache_line_length <= PBCH_BYTE_RESET;
    end else if (wr && wb_adr_i == PBCH_OFS_HDR_CACHE && wb_sel_i[0]) begin
      cache_line_length <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      upstream_bus_number   <= PBCH_BYTE_RESET;
      downstream_bus_number <= PBCH_BYTE_RESET;
    end else if (wr && wb_adr_i == PBCH_OFS_BUS_NUMBER) begin
      if (wb_sel_i[0]) begin
        upstream_bus_number <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        downstream_bus_number <= wb_dat_i[15:8];
      end
    end
  end

  // ==========================================================================
  // Read mux
  logic [31:0] rdata;
  logic [15:0] status_half;

  always_comb begin
    status_half       = 16'h0000;
    status_half[PBCH_BIT_CAP_LIST - 16]      = PBCH_CAP_LIST_VAL;
    status_half[PBCH_BIT_MASTER_PERR - 16]   = master_perr;
    status_half[PBCH_BIT_SIG_TGT_ABORT - 16] = sig_tgt_abort;
    status_half[PBCH_BIT_RCV_TGT_ABORT - 16] = rcv_tgt_abort;
    status_half[PBCH_BIT_RCV_MST_ABORT - 16] = rcv_mst_abort;
    status_half[PBCH_BIT_SIG_SYS_ERR - 16]   = sig_sys_err;
    status_half[PBCH_BIT_DET_PERR - 16]      = det_perr;
    case (wb_adr_i)
      PBCH_OFS_CMD_STATUS: begin
        rdata = {status_half, 7'h00, system_error_report_enable, 1'b0,
                 parity_err_resp_en, 6'h00};
      end
      PBCH_OFS_CLASS_REV: begin
        rdata = {PBCH_CLASS_BASE, PBCH_CLASS_SUB, PBCH_CLASS_PROG, DEVICE_REVISION};
      end
      PBCH_OFS_HDR_CACHE: begin
        rdata = {8'h00, PBCH_HEADER_TYPE, PBCH_LAT_TIMER, cache_line_length};
      end
      PBCH_OFS_BUS_NUMBER: begin
        rdata = {16'h0000, downstream_bus_number, upstream_bus_number};
      end
      default: begin
        rdata = PBCH_UNMAPPED_DATA;
      end
    endcase
  end

  // ==========================================================================
  // Wishbone answer: one cycle after the strobe, dropped the next cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rdata : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// file: pbch_config_header_props.sv
/* Checker for the config header bank: bus timing and fixed fields.
   Bound to pbch_config_header from the testbench file. */
`timescale 1ns/1ps
`default_nettype none
module pbch_config_header_props
  import pbch_pkg::*;
#(parameter logic [7:0] DEVICE_REVISION = 8'h5A) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        parity_err_resp_en,
  input wire logic [7:0]  upstream_bus_number,
  input wire logic [7:0]  downstream_bus_number
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Request taken, then read answered one cycle later
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(a);
    s_take ##0 (!wb_we_i && wb_adr_i == a) ##1 wb_ack_o;
  endsequence
  a_ack_latency: assert property (s_take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  a_status_fixed: assert property (s_rd(8'h04) |->
    wb_dat_o[23:16] == 8'h10 && wb_dat_o[26:25] == 2'b00) else $error("status fixed bits");
  a_class_rev: assert property (s_rd(8'h08) |->
    wb_dat_o == {8'h06, 8'h04, 8'h00, DEVICE_REVISION}) else $error("class code");
  a_hdr_fixed: assert property (s_rd(8'h0C) |->
    wb_dat_o[31:8] == 24'h000100) else $error("header byte");
  a_bus_mirror: assert property (s_rd(8'h18) |->
    wb_dat_o == {16'h0, downstream_bus_number, upstream_bus_number}) else $error("bus");
  a_perr_enable: assert property (s_take ##0 (wb_we_i && wb_adr_i == 8'h04 &&
    wb_sel_i[0]) |=> parity_err_resp_en == $past(wb_dat_i[6])) else $error("enable");
endmodule
`default_nettype wire

// file: pbch_cfg_host.sv
/* Host model: classic Wishbone master issuing config requests.
   Assumes the slave acks each request once, after some cycles. */
`timescale 1ns/1ps
`default_nettype none
module pbch_cfg_host (
  input  wire logic        sys_clk,
  input  wire logic        ack,
  output var  logic        cyc,
  output var  logic        stb,
  output var  logic        we,
  output var  logic [7:0]  adr,
  output var  logic [3:0]  sel,
  output var  logic [31:0] dat
);
  initial {cyc, stb, we, adr, sel, dat} = 47'h0;
  // Held until ack is sampled; released lines park at the inverse
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
    @(posedge sys_clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    {cyc, stb, we, adr, sel, dat} <= {2'b00, ~w, ~a, ~s, ~d};
  endtask
endmodule
`default_nettype wire

// file: tb_pbch_config_header.sv
/* Testbench for the config header bank: reset values, fields, events.
   Needs pbch_cfg_host and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_pbch_config_header import pbch_pkg::*;;
  localparam logic [7:0] REV = 8'h3C;  // Arbitrary value
  logic           sys_clk = 1'b0;
  logic           rst_n   = 1'b0;
  logic           cyc, stb, we, ack, perr_en, serr_en;
  logic [7:0]     adr, up_bus, down_bus;
  logic [3:0]     sel;
  logic [31:0]    dat_i, dat_o, rnd;
  pbch_event_type events  = '0;
  logic [31:0]    exp_q[$];
  int             miscompares = 0, checks_done = 0, seed = 32'h92A585EA;
  always #2.5 sys_clk = ~sys_clk;
  pbch_cfg_host u_pbch_cfg_host (.sys_clk(sys_clk), .ack(ack), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat(dat_i));
  pbch_config_header #(.DEVICE_REVISION(REV)) u_pbch_config_header (.sys_clk(sys_clk),
    .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .events(events),
    .parity_err_resp_en(perr_en), .system_error_report_enable(serr_en),
    .upstream_bus_number(up_bus), .downstream_bus_number(down_bus));
  task automatic cmp32(input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR read data expected %h seen %h", e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_pbch_cfg_host.xfer(1'b0, a, 4'hF, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    u_pbch_cfg_host.xfer(1'b1, a, s, d);
  endtask
  task automatic pulse(input pbch_event_type ev);
    @(posedge sys_clk);
    events <= ev;
    @(posedge sys_clk);
    events <= '0;
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Oldest note is compared whenever a read is answered
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() != 0) cmp32(exp_q.pop_front(), dat_o);
  end
  initial begin
    do_reset;
    rd(8'h04, 32'h0010_0000);
    rd(8'h0C, 32'h0001_0000);
    rd(8'h18, 32'h0);
    rd(8'h10, 32'h0);
    $display("test reset values done");
    rnd = $random(seed);
    wr(8'h0C, 4'hF, rnd);
    wr(8'h18, 4'hF, rnd);
    wr(8'h08, 4'hF, ~rnd);
    rd(8'h0C, {24'h000100, rnd[7:0]});
    rd(8'h08, {8'h06, 8'h04, 8'h00, REV});
    wr(8'h18, 4'h2, ~rnd);
    rd(8'h18, {16'h0, ~rnd[15:8], rnd[7:0]});
    cmp32({16'h0, ~rnd[15:8], rnd[7:0]}, {16'h0, down_bus, up_bus});
    wr(8'h04, 4'h3, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0010_0140);
    cmp32(32'h3, {30'h0, serr_en, perr_en});
    $display("test read write done");
    pulse(6'h3F);
    rd(8'h04, 32'hF910_0140);
    wr(8'h04, 4'hC, 32'h0);
    rd(8'h04, 32'hF910_0140);
    wr(8'h04, 4'hF, 32'hFFFF_0140);
    rd(8'h04, 32'h3810_0140);
    wr(8'h04, 4'h3, 32'h0);
    cmp32(32'h0, {30'h0, serr_en, perr_en});
    pulse(6'h22);
    pulse(6'h01);
    rd(8'h04, 32'hB810_0000);
    $display("test status events done");
    do_reset;
    rd(8'h04, 32'h0010_0000);
    $display("test second reset done");
    complete_run;
  end
  // About 4000 cycles, many times the expected run
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
endmodule
bind pbch_config_header pbch_config_header_props #(.DEVICE_REVISION(DEVICE_REVISION)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .parity_err_resp_en(parity_err_resp_en),
  .upstream_bus_number(upstream_bus_number), .downstream_bus_number(downstream_bus_number));
`default_nettype wire
